// ### exec_consts.vh
// register offsets, field positions, reset values and encodings
// assumes inclusion by bare name from the execution unit files
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// word byte offsets on the register bus
`define OFF_CMD 8'h00
`define OFF_IMM 8'h04
`define OFF_STATUS 8'h08
`define OFF_CTRLREG 8'h0c
`define OFF_MASKREG 8'h10
`define OFF_GPR_BASE 8'h40
`define GPR_COUNT 16

// command word fields
`define CMD_OP_LO 0
`define CMD_RD_LO 4
`define CMD_RN_LO 8
`define CMD_RM_LO 12
`define CMD_STYPE_LO 16
`define CMD_SAMT_LO 18
`define CMD_WIDE 24
`define CMD_SBIT 25
`define CMD_INCOND 26
`define CMD_SREG_LO 28

// status word fields
`define ST_N 31
`define ST_Z 30
`define ST_C 29
`define ST_V 28
`define ST_REFUSED 1
`define ST_PRIV 0

// operation codes
`define OP_NOP 4'h0
`define OP_MUL 4'h1
`define OP_MVN_IMM 4'h2
`define OP_MVN_REG 4'h3
`define OP_NEG 4'h4
`define OP_SREG_READ 4'h5
`define OP_SREG_WRITE 4'h6

// special register selects
`define SREG_APP 2'h0
`define SREG_CTRL 2'h1
`define SREG_MASK 2'h2

// shift types
`define SH_LSL 2'h0
`define SH_LSR 2'h1
`define SH_ASR 2'h2
`define SH_ROR 2'h3

// reset values
`define RST_FLAGS 4'h0
`define RST_CTRL 2'h0
`define RST_MASK 8'h00

`endif

// ### exec_unit.v
// execution unit for multiply, invert move, negate, hint and special moves
// assumes a classic wishbone master and a synchronous active-high reset
//
// Behaviour
// [RULE_01] multiply writes low 32 product bits
// [RULE_02] multiply flags only short form, outside block
// [RULE_03] set n, z; carry per op
// [RULE_04] immediate invert writes complemented expanded constant
// [RULE_05] register invert writes complemented shifted source
// [RULE_06] shift only in wide form
// [RULE_07] negate is flag-setting zero minus source
// [RULE_08] hint changes nothing at all
// [RULE_09] special read privileged except app, control
// [RULE_10] special write privileged except app status
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "exec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module exec_unit (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire wb_ack_o,
  output wire [31:0] wb_dat_o
);

  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // [RULE_09] [RULE_10] selects open to unprivileged code
  function sreg_open;
    input [1:0] sel;
    input for_read;
    begin
      sreg_open = (sel == `SREG_APP) | (for_read & (sel == `SREG_CTRL));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  reg ack_r;
  reg [31:0] dat_r;
  reg [31:0] dat_nxt;
  reg [11:0] imm_r;
  reg [3:0] flags_r;
  reg [3:0] flags_nxt;
  reg [1:0] ctrl_r;
  reg [1:0] ctrl_nxt;
  reg [7:0] mask_r;
  reg [7:0] mask_nxt;
  reg refused_r;
  reg [31:0] gpr_r [0:`GPR_COUNT-1];

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire commit = req & ack_r & wb_we_i;
  wire hit_gpr = (wb_adr_i[7:6] == 2'h1) & (wb_adr_i[1:0] == 2'h0);
  wire [3:0] gpr_idx = wb_adr_i[5:2];
  wire wr_cmd = commit & (wb_adr_i == `OFF_CMD) & (wb_sel_i == 4'hf);
  wire wr_imm = commit & (wb_adr_i == `OFF_IMM);
  wire wr_status = commit & (wb_adr_i == `OFF_STATUS);
  wire wr_ctrl = commit & (wb_adr_i == `OFF_CTRLREG);
  wire wr_mask = commit & (wb_adr_i == `OFF_MASKREG);
  wire wr_gpr_bus = commit & hit_gpr;

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // command fields
  wire [3:0] op = wb_dat_i[`CMD_OP_LO +: 4];
  wire [3:0] rd = wb_dat_i[`CMD_RD_LO +: 4];
  wire [3:0] rn = wb_dat_i[`CMD_RN_LO +: 4];
  wire [3:0] rm = wb_dat_i[`CMD_RM_LO +: 4];
  wire [1:0] stype = wb_dat_i[`CMD_STYPE_LO +: 2];
  wire [4:0] samt = wb_dat_i[`CMD_SAMT_LO +: 5];
  wire wide_form = wb_dat_i[`CMD_WIDE];
  wire sbit = wb_dat_i[`CMD_SBIT];
  wire in_cond = wb_dat_i[`CMD_INCOND];
  wire [1:0] sreg = wb_dat_i[`CMD_SREG_LO +: 2];
  wire privileged = ~ctrl_r[0];
  wire [31:0] opn_n = gpr_r[rn];
  wire [31:0] opn_m = gpr_r[rm];

  ////////////////////////////////////////////////////////////////////////
  // operand helpers
  wire [31:0] imm32;
  wire imm_carry;
  wire [31:0] shifted;
  wire shift_carry_o;

  // [RULE_06] short form forces lsl by zero
  wire [1:0] eff_stype = wide_form ? stype : `SH_LSL;
  wire [4:0] eff_samt = wide_form ? samt : 5'h00;

  // carry flag feeds both operand helpers
  wire carry_flag = flags_r[1];

  imm_expander u_imm (
    .imm12(imm_r),
    .carry_in(carry_flag),
    .imm32(imm32),
    .carry_out(imm_carry)
  );

  shift_carry u_shift (
    .value(opn_m),
    .stype(eff_stype),
    .amount(eff_samt),
    .carry_in(carry_flag),
    .shifted(shifted),
    .carry_out(shift_carry_o)
  );

  // [RULE_01] low word only, same for signed and unsigned
  wire [31:0] product = opn_n * opn_m;
  wire [32:0] neg_sum = {1'b0, ~opn_m} + 33'h000000001;

  ////////////////////////////////////////////////////////////////////////
  // execute
  reg [31:0] result;
  reg res_we;
  reg set_nz;
  reg load_c;
  reg load_v;
  reg new_c;
  reg new_v;
  reg refuse;
  reg [31:0] sreg_val;

  always @* begin
    result = 32'h00000000;
    res_we = 1'b0;
    set_nz = 1'b0;
    load_c = 1'b0;
    load_v = 1'b0;
    new_c = 1'b0;
    new_v = 1'b0;
    refuse = 1'b0;
    case (sreg)
      `SREG_APP: sreg_val = {flags_r, 28'h0000000};
      `SREG_CTRL: sreg_val = {30'h00000000, ctrl_r};
      `SREG_MASK: sreg_val = {24'h000000, mask_r};
      default: sreg_val = 32'h00000000;
    endcase
    if (wr_cmd) begin
      case (op)
        `OP_NOP: begin
          // [RULE_08] hint leaves all state
          res_we = 1'b0;
        end
        `OP_MUL: begin
          result = product;
          res_we = 1'b1;
          // [RULE_02] flags only in short form outside block
          set_nz = ~wide_form & ~in_cond;
        end
        `OP_MVN_IMM: begin
          // [RULE_04] complement of expanded constant
          result = ~imm32;
          res_we = 1'b1;
          set_nz = sbit;
          load_c = sbit;
          new_c = imm_carry;
        end
        `OP_MVN_REG: begin
          // [RULE_05] complement of shifted source
          result = ~shifted;
          res_we = 1'b1;
          set_nz = wide_form ? sbit : ~in_cond;
          load_c = wide_form ? sbit : ~in_cond;
          new_c = shift_carry_o;
        end
        `OP_NEG: begin
          // [RULE_07] zero minus source with flags
          result = neg_sum[31:0];
          res_we = 1'b1;
          set_nz = 1'b1;
          load_c = 1'b1;
          load_v = 1'b1;
          new_c = neg_sum[32];
          new_v = opn_m[31] & neg_sum[31];
        end
        `OP_SREG_READ: begin
          // [RULE_09] read gated by privilege
          refuse = ~privileged & ~sreg_open(sreg, 1'b1);
          result = sreg_val;
          res_we = ~refuse;
        end
        `OP_SREG_WRITE: begin
          // [RULE_10] write gated by privilege
          refuse = ~privileged & ~sreg_open(sreg, 1'b0);
        end
        default: begin
          // [RULE_08] hint does nothing
          res_we = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag and special register next values
  wire sreg_wr = wr_cmd & (op == `OP_SREG_WRITE) & ~refuse;

  always @* begin
    flags_nxt = flags_r;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    if (wr_status) begin
      flags_nxt = wb_sel_i[3] ? wb_dat_i[`ST_N:`ST_V] : flags_r;
    end
    if (wr_ctrl) begin
      ctrl_nxt = wb_sel_i[0] ? wb_dat_i[1:0] : ctrl_r;
    end
    if (wr_mask) begin
      mask_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : mask_r;
    end
    // [RULE_03] n from bit 31, z on zero
    if (set_nz) begin
      flags_nxt[3] = result[31];
      flags_nxt[2] = (result == 32'h00000000);
    end
    // [RULE_03] carry only where the op defines it
    if (load_c) begin
      flags_nxt[1] = new_c;
    end
    // [RULE_03] overflow only from negate
    if (load_v) begin
      flags_nxt[0] = new_v;
    end
    // [RULE_10] accepted special write
    if (sreg_wr) begin
      case (sreg)
        `SREG_APP: flags_nxt = opn_n[31:28];
        `SREG_CTRL: ctrl_nxt = opn_n[1:0];
        `SREG_MASK: mask_nxt = opn_n[7:0];
        default: mask_nxt = mask_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // general registers
  genvar g;
  generate
    for (g = 0; g < `GPR_COUNT; g = g + 1) begin : gpr_gen
      always @(posedge mclk) begin
        if (rst) begin
          gpr_r[g] <= 32'h00000000;
        end else if (wr_gpr_bus && gpr_idx == g) begin
          gpr_r[g] <= merge(gpr_r[g], wb_dat_i, wb_sel_i);
        end else if (res_we && rd == g) begin
          gpr_r[g] <= result;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux
  wire [31:0] status_word = {flags_r, 26'h0000000, refused_r, privileged};
  always @* begin
    dat_nxt = 32'h00000000;
    if (hit_gpr) begin
      dat_nxt = gpr_r[gpr_idx];
    end else begin
      case (wb_adr_i)
        `OFF_IMM: dat_nxt = {20'h00000, imm_r};
        `OFF_STATUS: dat_nxt = status_word;
        `OFF_CTRLREG: dat_nxt = {30'h00000000, ctrl_r};
        `OFF_MASKREG: dat_nxt = {24'h000000, mask_r};
        default: dat_nxt = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, ack for one cycle
  always @(posedge mclk) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        dat_r <= wb_we_i ? 32'h00000000 : dat_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // architectural state
  wire [31:0] imm_merged = merge({20'h00000, imm_r}, wb_dat_i, wb_sel_i);

  always @(posedge mclk) begin
    if (rst) begin
      imm_r <= 12'h000;
      flags_r <= `RST_FLAGS;
      ctrl_r <= `RST_CTRL;
      mask_r <= `RST_MASK;
    end else begin
      if (wr_imm) begin
        imm_r <= imm_merged[11:0];
      end
      flags_r <= flags_nxt;
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refused flag: new refusal wins over write-one clear
  always @(posedge mclk) begin
    if (rst) begin
      refused_r <= 1'b0;
    end else if (refuse) begin
      refused_r <= 1'b1;
    end else if (wr_status && wb_sel_i[0] && wb_dat_i[`ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

endmodule // exec_unit
`default_nettype wire

// ### exec_unit_monitor.sv
// bus timing checks for the execution unit
// assumes classic wishbone slave ports, one clock
`timescale 1ns/1ps
`default_nettype none
module exec_unit_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_ack = wb_ack_o && !wb_we_i;
  ////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RESET: assert property (disable iff (1'b0) rst |=> !wb_ack_o && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  AST_DAT_HOLD: assert property (!take |=> $stable(wb_dat_o))
    else $error("read data moved without access");
  AST_WR_DAT_ZERO: assert property (take && wb_we_i |=> wb_dat_o == 32'h0)
    else $error("write ack carries data");
  AST_CMD_ZERO: assert property (rd_ack && wb_adr_i == 8'h00 |-> wb_dat_o == 32'h0)
    else $error("command word read not zero");
  AST_UNMAPPED: assert property (rd_ack && wb_adr_i >= 8'h14 && wb_adr_i < 8'h40 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS_RSV: assert property (rd_ack && wb_adr_i == 8'h08 |-> wb_dat_o[27:2] == 26'h0)
    else $error("status spare bits set");
endmodule // exec_unit_monitor
bind exec_unit exec_unit_monitor mon_i (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o);
`default_nettype wire

// ### imm_expander.v
// modified immediate expansion with carry out
// assumes a 12-bit field i:imm3:imm8 and the current carry flag
`timescale 1ns/1ps
`default_nettype none
module imm_expander (
  input wire [11:0] imm12,
  input wire carry_in,
  output reg [31:0] imm32,
  output reg carry_out
);
  reg [31:0] unrot;
  reg [4:0] rot;
  always @* begin
    unrot = {24'h000000, 1'b1, imm12[6:0]};
    rot = imm12[11:7];
    imm32 = 32'h00000000;
    carry_out = carry_in;
    if (imm12[11:10] == 2'h0) begin
      case (imm12[9:8])
        2'h0: imm32 = {24'h000000, imm12[7:0]};
        2'h1: imm32 = {8'h00, imm12[7:0], 8'h00, imm12[7:0]};
        2'h2: imm32 = {imm12[7:0], 8'h00, imm12[7:0], 8'h00};
        default: imm32 = {4{imm12[7:0]}};
      endcase
    end else begin
      imm32 = (unrot >> rot) | (unrot << (6'h20 - {1'b0, rot}));
      carry_out = imm32[31];
    end
  end
endmodule // imm_expander
`default_nettype wire

// ### shift_carry.v
// operand shifter with carry out, immediate shift decode included
// assumes type and 5-bit amount as encoded in a wide instruction
`include "exec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module shift_carry (
  input wire [31:0] value,
  input wire [1:0] stype,
  input wire [4:0] amount,
  input wire carry_in,
  output reg [31:0] shifted,
  output reg carry_out
);
  reg [5:0] n;
  reg [63:0] wide;
  always @* begin
    n = (amount == 5'h00 && (stype == `SH_LSR || stype == `SH_ASR)) ? 6'h20 : {1'b0, amount};
    wide = 64'h0;
    shifted = value;
    carry_out = carry_in;
    case (stype)
      `SH_LSL: begin
        if (n != 6'h00) begin
          wide = {32'h00000000, value} << n;
          shifted = wide[31:0];
          carry_out = wide[32];
        end
      end
      `SH_LSR: begin
        wide = {value, 32'h00000000} >> n;
        shifted = wide[63:32];
        carry_out = wide[31];
      end
      `SH_ASR: begin
        wide = $signed({value, 32'h00000000}) >>> n;
        shifted = wide[63:32];
        carry_out = wide[31];
      end
      default: begin
        if (n == 6'h00) begin
          shifted = {carry_in, value[31:1]};
          carry_out = value[0];
        end else begin
          shifted = (value >> n[4:0]) | (value << (6'h20 - n));
          carry_out = shifted[31];
        end
      end
    endcase
  end
endmodule // shift_carry
`default_nettype wire

// ### tb.sv
// testbench: commands and register reads over wishbone
// assumes exec_unit and its monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, got;
  wire ack;
  wire [31:0] dout;
  int bad_count, check_count, ticks;
  exec_unit exec_unit_i (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dout));
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      got = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check_count++;
      if (got !== e) begin
        bad_count++;
        $display("wrong value at %0t got %h expected %h", $time, got, e);
      end
    end
  endtask
  task automatic x(input logic [31:0] c);
    bus(1'b1, 8'h00, c);
  endtask
  function automatic logic [7:0] g(input logic [3:0] i);
    g = 8'h40 + {2'b00, i, 2'b00};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 3000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    {rst, cyc, stb, we, adr, sel, dat, ticks} = {1'b1, 79'h0};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h08, 32'h00000001);
    bus(1'b1, g(4'h1), 32'hffffffff);
    bus(1'b1, g(4'h2), 32'h00000003);
    x(32'h00002131);
    rd(g(4'h3), 32'hfffffffd);
    rd(8'h08, 32'h80000001);
    x(32'h01000141);
    rd(g(4'h4), 32'h0);
    x(32'h04000161);
    rd(8'h08, 32'h80000001);
    bus(1'b1, 8'h04, 32'h0000047f);
    x(32'h02000052);
    rd(g(4'h5), 32'h00ffffff);
    rd(8'h08, 32'h20000001);
    rd(8'h04, 32'h0000047f);
    x(32'h03052063);
    rd(g(4'h6), 32'hfffffffe);
    rd(8'h08, 32'ha0000001);
    x(32'h00052073);
    rd(g(4'h7), 32'hfffffffc);
    rd(8'h08, 32'ha0000001);
    x(32'h00002284);
    rd(g(4'h8), 32'hfffffffd);
    rd(8'h08, 32'h80000001);
    x(32'h00000094);
    rd(g(4'h9), 32'h0);
    rd(8'h08, 32'h60000001);
    for (int i = 0; i < 2; i++) begin
      x(i ? 32'h01002130 : 32'h00002130);
      rd(g(4'h3), 32'hfffffffd);
    end
    rd(8'h08, 32'h60000001);
    x(32'h000000a5);
    rd(g(4'ha), 32'h60000000);
    x(32'h00000106);
    rd(8'h08, 32'hf0000001);
    bus(1'b1, 8'h0c, 32'h00000001);
    rd(8'h08, 32'hf0000000);
    x(32'h100000b5);
    rd(g(4'hb), 32'h00000001);
    x(32'h200000c5);
    rd(g(4'hc), 32'h0);
    rd(8'h08, 32'hf0000002);
    bus(1'b1, 8'h08, 32'hf0000002);
    x(32'h00000206);
    rd(8'h08, 32'h00000000);
    x(32'h10000006);
    rd(8'h08, 32'h00000002);
    rd(8'h0c, 32'h00000001);
    rd(8'h00, 32'h0);
    rd(8'h20, 32'h0);
    bus(1'b1, 8'h0c, 32'h00000000);
    bus(1'b1, 8'h08, 32'h00000002);
    rd(8'h08, 32'h00000001);
    x(32'h20000206);
    rd(8'h10, 32'h00000003);
    x(32'h200000d5);
    rd(g(4'hd), 32'h00000003);
    bus(1'b1, 8'h08, 32'h10000000);
    x(32'h030410e3);
    rd(g(4'he), 32'h00000001);
    rd(8'h08, 32'h30000001);
    x(32'h030210f3);
    rd(g(4'hf), 32'h0);
    rd(8'h08, 32'h70000001);
    x(32'h031320e3);
    rd(g(4'he), 32'hcfffffff);
    rd(8'h08, 32'h90000001);
    bus(1'b1, 8'h08, 32'h20000000);
    x(32'h030320f3);
    rd(g(4'hf), 32'h7ffffffe);
    rd(8'h08, 32'h20000001);
    bus(1'b1, 8'h04, 32'h000001ab);
    x(32'h020000c2);
    rd(g(4'hc), 32'hff54ff54);
    rd(8'h08, 32'ha0000001);
    // second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h08, 32'h00000001);
    rd(g(4'h1), 32'h0);
    close_out;
  end
endmodule // tb
`default_nettype wire
